// ### rtl/imsc_regs.vh
// imsc_regs.vh: register offsets, field positions, reset values and timing counts
// assumes a 10 MHz clock and a 32-bit APB register bus
`ifndef IMSC_REGS_VH
`define IMSC_REGS_VH
// ==========================================
// register byte offsets
`define IMSC_OFF_CMD 12'h000
`define IMSC_OFF_RESULT 12'h004
`define IMSC_OFF_STATUS 12'h008
`define IMSC_OFF_PEND 12'h00C
`define IMSC_OFF_MASK 12'h010
`define IMSC_OFF_SERVICE 12'h014
// ==========================================
// command word fields: operand [15:0], source [18:16], control code [21:20]
`define IMSC_CMD_OPND_LSB 0
`define IMSC_CMD_OPND_MSB 15
`define IMSC_CMD_SRC_LSB 16
`define IMSC_CMD_SRC_MSB 18
`define IMSC_CMD_CC_LSB 20
`define IMSC_CMD_CC_MSB 21
// ==========================================
// control codes and sources
`define IMSC_CC_SET 2'h0
`define IMSC_CC_CLEAR 2'h1
`define IMSC_CC_READ 2'h2
`define IMSC_SRC_UNIT_LAST 3'h3
`define IMSC_SRC_SCHED 3'h4
// ==========================================
// reset values
`define IMSC_MASK_RST 8'hFF
`define IMSC_TIME_RST 16'h0000
// ==========================================
// timing: one tick of the interval timer is 0.01 s
`define IMSC_TICK_MS 10
`define IMSC_CLK_KHZ 10000
`define IMSC_TICK_CYC (`IMSC_TICK_MS * `IMSC_CLK_KHZ)
`endif

// ### rtl/imsc_bcd_timer.v
// imsc_bcd_timer.v: four-digit decimal down counter of hundredths of a second
// assumes load and tick pulses from the same clock; stops at zero when disarmed
`timescale 1ns/10ps
`include "imsc_regs.vh"
module imsc_bcd_timer
(
    input wire clk,
    input wire rst_n,
    input wire load,
    input wire [15:0] loadValue,
    input wire tick,
    output reg [15:0] count_reg,
    output reg expired_reg
);
    // ==========================================
    // decimal decrement, four-digit borrow chain
    reg [15:0] count_next;
    reg borrow;
    integer i;
    always @*
    begin
        count_next = count_reg;
        borrow = 1'b1;
        for (i = 0; i < 4; i = i + 1)
        begin
            if (borrow)
            begin
                if (count_reg[i*4 +: 4] == 4'h0)
                begin
                    count_next[i*4 +: 4] = 4'h9;
                end
                else
                begin
                    count_next[i*4 +: 4] = count_reg[i*4 +: 4] - 4'h1;
                    borrow = 1'b0;
                end
            end
        end
    end

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            count_reg <= `IMSC_TIME_RST;
            expired_reg <= 1'b0;
        end
        else
        begin
            expired_reg <= 1'b0;
            if (load)
            begin
                count_reg <= loadValue;
            end
            else if (tick && count_reg != 16'h0000)
            begin
                count_reg <= count_next;
                expired_reg <= (count_reg == 16'h0001);
            end
        end
    end
endmodule

// ### rtl/imsc_top.v
// imsc_top.v: interrupt mask and schedule control with an APB register slave
// assumes unit interrupt inputs are asynchronous pins and apb is on clk
//
// Overview of operation
// R1: source 0-3 picks unit, 4 scheduled
// R2: subroutine number is unit times eight plus bit
// R3: code 0 loads unit mask from operand
// R4: masked interrupts latch pending, run on unmask
// R5: code 1 clears pending of masked bits
// R6: code 2 returns unit mask status
// R7: code 0 scheduled sets decimal repeat interval
// R8: operand 00.00 cancels scheduled interrupt
// R9: code 1 scheduled sets first delay
// R10: code 2 scheduled returns programmed interval
// R11: program issues only valid codes and sources
// R12: scheduled interrupt repeats until cancelled
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/10ps
`include "imsc_regs.vh"
module imsc_top
#(
    parameter UNITS = 4,
    parameter TICK_CYCLES = `IMSC_TICK_CYC
)
(
    input wire clk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [UNITS*8-1:0] unitIrq,
    output reg serviceValid_reg,
    output reg [4:0] serviceNum_reg,
    output reg schedIrq_reg
);
    // ==========================================
    // apb slave, one wait state: access phase seen, then pready for one cycle
    localparam ST_IDLE = 2'h1;
    localparam ST_ACK = 2'h2;
    reg [1:0] state_reg;
    reg [1:0] state_next;
    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
            begin
                if (psel && penable)
                begin
                    state_next = ST_ACK;
                end
            end
            ST_ACK:
            begin
                state_next = ST_IDLE;
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
    end
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_reg <= ST_IDLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end
    wire access = psel && penable && state_reg == ST_IDLE;
    // writes act at the edge that completes the transfer, when the master sees pready
    wire take = psel && penable && pready && pwrite;
    wire wrCmd = take && paddr == `IMSC_OFF_CMD;
    wire wrService = take && paddr == `IMSC_OFF_SERVICE;
    wire [1:0] cmdCode = pwdata[`IMSC_CMD_CC_MSB:`IMSC_CMD_CC_LSB];
    wire [2:0] cmdSrc = pwdata[`IMSC_CMD_SRC_MSB:`IMSC_CMD_SRC_LSB];
    wire [15:0] cmdOpnd = pwdata[`IMSC_CMD_OPND_MSB:`IMSC_CMD_OPND_LSB];
    wire srcUnit = cmdSrc <= `IMSC_SRC_UNIT_LAST; // R1
    wire srcSched = cmdSrc == `IMSC_SRC_SCHED; // R1
    // a non-decimal digit would run the timer through codes it never counts from
    wire [3:0] digitOk;
    genvar d;
    generate
        for (d = 0; d < 4; d = d + 1)
        begin : digitGen
            assign digitOk[d] = cmdOpnd[d*4 +: 4] <= 4'h9;
        end
    endgenerate
    wire opndBad = srcSched && cmdCode != `IMSC_CC_READ && digitOk != 4'hF; // R7
    // bad code or source is flagged, never acted upon
    wire cmdBad = cmdCode > `IMSC_CC_READ || cmdSrc > `IMSC_SRC_SCHED || opndBad; // R11

    // ==========================================
    // input synchronisers, three stages, change once stages two and three agree
    reg [UNITS*8-1:0] sync1_reg;
    reg [UNITS*8-1:0] sync2_reg;
    reg [UNITS*8-1:0] sync3_reg;
    reg [UNITS*8-1:0] level_reg;
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            sync1_reg <= {UNITS*8{1'b0}};
            sync2_reg <= {UNITS*8{1'b0}};
            sync3_reg <= {UNITS*8{1'b0}};
            level_reg <= {UNITS*8{1'b0}};
        end
        else
        begin
            sync1_reg <= unitIrq;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            level_reg <= (sync2_reg & sync3_reg) | (level_reg & (sync2_reg | sync3_reg));
        end
    end
    wire [UNITS*8-1:0] riseLevel;
    reg [UNITS*8-1:0] levelDly_reg;
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            levelDly_reg <= {UNITS*8{1'b0}};
        end
        else
        begin
            levelDly_reg <= level_reg;
        end
    end
    assign riseLevel = level_reg & ~levelDly_reg;

    // ==========================================
    // per unit mask and pending latches
    reg [UNITS*8-1:0] mask_reg;
    reg [UNITS*8-1:0] pend_reg;
    wire [UNITS*8-1:0] grant;
    genvar u;
    generate
        for (u = 0; u < UNITS; u = u + 1)
        begin : unitGen
            wire sel = srcUnit && cmdSrc[1:0] == u;
            always @(posedge clk)
            begin
                if (!rst_n)
                begin
                    mask_reg[u*8 +: 8] <= `IMSC_MASK_RST;
                    pend_reg[u*8 +: 8] <= 8'h00;
                end
                else
                begin
                    if (wrCmd && !cmdBad && sel && cmdCode == `IMSC_CC_SET)
                    begin
                        mask_reg[u*8 +: 8] <= cmdOpnd[7:0]; // R3
                    end
                    // new edges set pending; set wins over any clear in the same cycle
                    if (wrCmd && !cmdBad && sel && cmdCode == `IMSC_CC_CLEAR)
                    begin
                        pend_reg[u*8 +: 8] <= (pend_reg[u*8 +: 8] & ~(cmdOpnd[7:0] & mask_reg[u*8 +: 8]) // R5
                            & ~grant[u*8 +: 8]) | riseLevel[u*8 +: 8]; // R4
                    end
                    else
                    begin
                        pend_reg[u*8 +: 8] <= (pend_reg[u*8 +: 8] & ~grant[u*8 +: 8]) | riseLevel[u*8 +: 8]; // R4
                    end
                end
            end
        end
    endgenerate

    // ==========================================
    // priority pick of the lowest unmasked pending subroutine, held until served
    // lowest number wins, so unit 0 bit 0 is served first
    // more than four units would need a wider subroutine number
    wire [UNITS*8-1:0] ready = pend_reg & ~mask_reg; // R4
    reg [4:0] pick;
    reg pickAny;
    integer k;
    always @*
    begin
        pick = 5'h00;
        pickAny = 1'b0;
        for (k = UNITS*8-1; k >= 0; k = k - 1)
        begin
            if (ready[k])
            begin
                pick = k[4:0]; // R2
                pickAny = 1'b1;
            end
        end
    end
    wire serviceAck = wrService && serviceValid_reg;
    assign grant = serviceAck ? ({{UNITS*8-1{1'b0}}, 1'b1} << serviceNum_reg) : {UNITS*8{1'b0}};
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            serviceValid_reg <= 1'b0;
            serviceNum_reg <= 5'h00;
        end
        else if (!serviceValid_reg || serviceAck)
        begin
            // a grant consumes a pick; the next one appears a cycle later
            serviceValid_reg <= pickAny && !serviceAck;
            serviceNum_reg <= pick; // R2
        end
    end

    // ==========================================
    // scheduled interrupt: interval and first delay in hundredths of a second
    reg [15:0] interval_reg;
    reg armed_reg;
    reg [31:0] div_reg;
    reg tick_reg;
    wire schedWr = wrCmd && !cmdBad && srcSched && cmdCode != `IMSC_CC_READ;
    wire cancel = schedWr && cmdOpnd == 16'h0000; // R8
    wire [15:0] timerCount;
    wire timerExpired;
    wire timerLoad = (schedWr && !cancel) || (armed_reg && timerExpired);
    wire [15:0] timerValue = schedWr ? cmdOpnd : interval_reg;
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            div_reg <= 32'h00000000;
            tick_reg <= 1'b0;
        end
        else if (div_reg >= TICK_CYCLES - 1)
        begin
            div_reg <= 32'h00000000;
            tick_reg <= 1'b1;
        end
        else
        begin
            div_reg <= div_reg + 32'h00000001;
            tick_reg <= 1'b0;
        end
    end
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            interval_reg <= `IMSC_TIME_RST;
            armed_reg <= 1'b0;
            schedIrq_reg <= 1'b0;
        end
        else
        begin
            schedIrq_reg <= armed_reg && timerExpired && !cancel;
            if (cancel)
            begin
                armed_reg <= 1'b0; // R8
                interval_reg <= `IMSC_TIME_RST; // R8
            end
            else if (schedWr && cmdCode == `IMSC_CC_SET)
            begin
                interval_reg <= cmdOpnd; // R7
                armed_reg <= 1'b1;
            end
            else if (schedWr)
            begin
                armed_reg <= 1'b1; // R9
            end
            else if (armed_reg && timerExpired && interval_reg == 16'h0000)
            begin
                armed_reg <= 1'b0;
            end
        end
    end
    // reload with the interval after each expiry so it repeats until cancelled
    // cancel also empties the counter so a stale count never fires
    imsc_bcd_timer schedTimer
    (
        .clk(clk),
        .rst_n(rst_n && !cancel),
        .load(timerLoad), // R12
        .loadValue(timerValue), // R9
        .tick(tick_reg),
        .count_reg(timerCount),
        .expired_reg(timerExpired)
    );

    // ==========================================
    // result word of the last read command and apb read mux
    reg [15:0] result_reg;
    reg badCmd_reg;
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            result_reg <= 16'h0000;
            badCmd_reg <= 1'b0;
        end
        else if (wrCmd)
        begin
            badCmd_reg <= cmdBad;
            if (!cmdBad && cmdCode == `IMSC_CC_READ && srcUnit)
            begin
                result_reg <= {8'h00, mask_reg[cmdSrc[1:0]*8 +: 8]}; // R6
            end
            else if (!cmdBad && cmdCode == `IMSC_CC_READ && srcSched)
            begin
                result_reg <= interval_reg; // R10
            end
        end
    end
    reg [31:0] rdata;
    reg known;
    always @*
    begin
        rdata = 32'h00000000;
        known = 1'b1;
        case (paddr)
            `IMSC_OFF_CMD: rdata = 32'h00000000;
            `IMSC_OFF_RESULT: rdata = {16'h0000, result_reg};
            `IMSC_OFF_STATUS: rdata = {timerCount, 5'h00, armed_reg, badCmd_reg, serviceValid_reg, 3'h0, serviceNum_reg};
            `IMSC_OFF_PEND: rdata = pend_reg;
            `IMSC_OFF_MASK: rdata = mask_reg;
            `IMSC_OFF_SERVICE: rdata = {27'h0000000, serviceNum_reg};
            default: known = 1'b0;
        endcase
    end
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else
        begin
            pready <= access;
            pslverr <= access && !known;
            prdata <= (access && !pwrite) ? rdata : 32'h00000000;
        end
    end
endmodule

// ### sim/imsc_props.sv
// imsc_props.sv: port-level checks for imsc_top
// assumes one clock and a sync active-low reset
`timescale 1ns/10ps
module imsc_props
(
    input wire clk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire pslverr,
    input wire serviceValid_reg,
    input wire schedIrq_reg
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ==========================================
    // helpers
    wire done = psel && penable && pready;
    wire sCmd = done && pwrite && paddr == 12'h000 && pwdata[18:16] == 3'h4 && pwdata[21:20] != 2'h2;
    wire ack = done && pwrite && paddr == 12'h014;
    wire wrDone = done && pwrite;
    reg ivlOne_reg;
    // only the shortest interval is tracked, longer ones outrun a delay range
    always @(posedge clk)
    begin
        if (!rst_n)
            ivlOne_reg <= 1'b0;
        else if (sCmd && pwdata[21:20] == 2'h0)
            ivlOne_reg <= pwdata[15:0] == 16'h0001;
        else if (sCmd && pwdata[15:0] == 16'h0000)
            ivlOne_reg <= 1'b0;
    end
    sequence setupAccess;
        psel && !penable ##1 psel && penable;
    endsequence
    sequence quietSched;
        !schedIrq_reg [*8];
    endsequence
    // ==========================================
    // assertions
    a_ready_one_wait: assert property (setupAccess |=> pready) else $error("pready late");
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
    a_unmapped_err: assert property (done && paddr > 12'h014 |-> pslverr) else $error("no pslverr");
    a_mapped_ok: assert property (done && paddr <= 12'h014 && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("false pslverr");
    a_sched_single: assert property (schedIrq_reg |=> !schedIrq_reg) else $error("long pulse");
    a_sched_cancel: assert property (sCmd && pwdata[15:0] == 16'h0000 |-> ##2 quietSched)
        else $error("fired after cancel");
    a_sched_repeat: assert property (schedIrq_reg && ivlOne_reg |-> ##[1:8] (schedIrq_reg || !ivlOne_reg))
        else $error("no repeat");
    a_ack_drops: assert property (ack && serviceValid_reg |-> ##[1:2] !serviceValid_reg)
        else $error("service kept");
    a_valid_kept: assert property ($fell(serviceValid_reg) |->
        $past(wrDone) || $past(wrDone, 2) || $past(wrDone, 3)) else $error("service lost");
endmodule
bind imsc_top imsc_props u_props (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .serviceValid_reg(serviceValid_reg),
    .schedIrq_reg(schedIrq_reg));

// ### sim/imsc_unit_model.sv
// imsc_unit_model.sv: interrupt input units driving the raw pins
// assumes one request at a time on the bench clock
`timescale 1ns/10ps
module imsc_unit_model
(
    input wire clk,
    input wire go,
    input wire [4:0] which,
    output logic [31:0] unitIrq
);
    int hold = 0;
    initial unitIrq = 32'h0;
    // held for 9 cycles so the pin synchronisers see the edge
    always @(posedge clk)
    begin
        if (go)
        begin
            unitIrq[which] <= 1'b1;
            hold <= 8;
        end
        else if (hold > 0)
            hold <= hold - 1;
        else
            unitIrq <= 32'h0;
    end
endmodule

// ### sim/testbench.sv
// testbench.sv: self-checking bench for imsc_top
// assumes the unit model on the pins and an APB master here
`timescale 1ns/10ps
module testbench;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, unitIrq;
    logic pready, pslverr, sv, sIrq;
    logic [4:0] sn, which = 5'h00;
    logic [7:0] m;
    logic [15:0] t;
    int err_total = 0, checked = 0, n, k, u;
    always #50 clk = ~clk;
    imsc_top #(.TICK_CYCLES(4)) DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .unitIrq(unitIrq),
        .serviceValid_reg(sv), .serviceNum_reg(sn), .schedIrq_reg(sIrq));
    imsc_unit_model units (.clk(clk), .go(go), .which(which), .unitIrq(unitIrq));
    // ==========================================
    // tasks
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task cmd(input logic [1:0] cc, input logic [2:0] src, input logic [15:0] op);
        apb(1'b1, 12'h000, {10'h000, cc, 1'b0, src, op});
    endtask
    task rdRes(input logic [2:0] src);
        cmd(2'h2, src, 16'h0000);
        apb(1'b0, 12'h004, 32'h0);
    endtask
    task fire(input int q);
        @(posedge clk);
        go <= 1'b1;
        which <= q[4:0];
        @(posedge clk);
        go <= 1'b0;
        repeat (12) @(posedge clk);
    endtask
    task count(input int cyc);
        n = 0;
        repeat (cyc) @(posedge clk) if (sIrq === 1'b1) n++;
    endtask
    function logic [15:0] toBcd(input int v);
        return {4'(v / 1000), 4'((v / 100) % 10), 4'((v / 10) % 10), 4'(v % 10)};
    endfunction
    task summarize;
        if (err_total == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ==========================================
    // tests
    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        summarize();
    end
    initial
    begin
        void'($urandom(32'h3F7B));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        for (u = 0; u < 4; u++)
        begin
            rdRes(3'(u));
            chk("reset mask", rd[7:0], 8'hFF);
            m = 8'($urandom);
            cmd(2'h0, 3'(u), {8'h00, m});
            rdRes(3'(u));
            chk("unit mask", rd[7:0], m);
        end
        for (u = 0; u < 4; u++)
        begin
            k = u == 0 ? 0 : u == 1 ? 31 : $urandom_range(30, 1);
            cmd(2'h0, 3'(k / 8), 16'h00FF);
            fire(k);
            if (u == 3)
                cmd(2'h1, 3'(k / 8), 16'(1 << (k % 8)));
            chk("masked idle", sv, 1'b0);
            cmd(2'h0, 3'(k / 8), 16'h0000);
            repeat (8) @(posedge clk);
            chk("service valid", sv, u != 3);
            if (u != 3)
                chk("service num", sn, k);
            apb(1'b1, 12'h014, 32'h0);
        end
        cmd(2'h3, 3'h5, 16'h0000);
        apb(1'b0, 12'h008, 32'h0);
        chk("bad command", rd[9], 1'b1);
        apb(1'b0, 12'h018, 32'h0);
        chk("unmapped err", er, 1'b1);
        chk("unmapped data", rd, 32'h0);
        t = toBcd($urandom_range(9999, 1));
        cmd(2'h0, 3'h4, t);
        rdRes(3'h4);
        chk("interval", rd[15:0], t);
        cmd(2'h0, 3'h4, 16'h0001);
        count(40);
        chk("repeat rate", n >= 9 && n <= 11, 1'b1);
        cmd(2'h1, 3'h4, 16'h0000);
        count(40);
        chk("cancelled", n, 0);
        rdRes(3'h4);
        chk("interval cleared", rd[15:0], 16'h0000);
        cmd(2'h1, 3'h4, toBcd(3));
        count(8);
        chk("first delay early", n, 0);
        count(40);
        chk("first delay", n, 1);
        summarize();
    end
endmodule
